// ### pkg/vfs_consts.svh
// constants for the two-rail fault supervisor: counter width and timing counts
// assumes a single 40 MHz block clock; times are kept in ns, counts derived
`ifndef VFS_CONSTS_SVH
`define VFS_CONSTS_SVH

// block clock rate
`define VFS_CLK_MHZ 40
// width of every fault timer
`define VFS_CNT_W 16

// phase current imbalance must persist this long (least time, round up)
`define VFS_IMB_TIME_NS 1000000
`define VFS_IMB_CYCLES ((`VFS_IMB_TIME_NS * `VFS_CLK_MHZ + 999) / 1000)

// overcurrent fault timer window, least and longest
`define VFS_OC_MIN_TIME_NS 7500
`define VFS_OC_MAX_TIME_NS 11000
`define VFS_OC_MIN_CYCLES ((`VFS_OC_MIN_TIME_NS * `VFS_CLK_MHZ + 999) / 1000)
`define VFS_OC_MAX_CYCLES ((`VFS_OC_MAX_TIME_NS * `VFS_CLK_MHZ) / 1000)

// least thermal warning time before shutdown
`define VFS_THERM_TIME_NS 100000
`define VFS_THERM_CYCLES ((`VFS_THERM_TIME_NS * `VFS_CLK_MHZ + 999) / 1000)

// soft-start duration before power-good may rise
`define VFS_SS_TIME_NS 100000
`define VFS_SS_CYCLES ((`VFS_SS_TIME_NS * `VFS_CLK_MHZ + 999) / 1000)

// rail indices
`define VFS_RAIL_CORE 0
`define VFS_RAIL_AUX 1

`endif

// ### pkg/vfs_pkg.sv
// types shared by the fault supervisor modules
// assumes vfs_consts.svh is on the include path
`include "vfs_consts.svh"

package vfs_pkg;

  // fault timer value
  typedef logic [`VFS_CNT_W-1:0] vfs_cnt_t;

  // overvoltage discharge sequence of one rail
  typedef enum logic [1:0] {
    VFS_OV_WATCH,
    VFS_OV_DISCH,
    VFS_OV_OFF
  } vfs_ov_e;

  // power-up sequence shared by both rails
  typedef enum logic [1:0] {
    VFS_SEQ_OFF,
    VFS_SEQ_SOFT,
    VFS_SEQ_RUN
  } vfs_seq_e;

endpackage : vfs_pkg

// ### pkg/vfs_rail_if.sv
// carrier between the supervisor top and one rail monitor
// assumes both ends share one clock
`timescale 1ns/1ps
`default_nettype none

interface vfs_rail_if;
  logic run;
  logic clear;
  logic fault_imb;
  logic fault_uv;
  logic fault_oc;
  logic fault_woc;
  logic ov_flag;
  logic ls_on;
  logic oc_alert;

  modport mon (input run, input clear, output fault_imb, output fault_uv, output fault_oc,
               output fault_woc, output ov_flag, output ls_on, output oc_alert);
  modport sup (output run, output clear, input fault_imb, input fault_uv, input fault_oc,
               input fault_woc, input ov_flag, input ls_on, input oc_alert);
endinterface : vfs_rail_if

`default_nettype wire

// ### hdl/vfs_rail_mon.sv
// per-rail fault monitor: imbalance, under/overvoltage, overcurrent timers
// assumes raw comparator flags are asynchronous; clear and run come from the top
`timescale 1ns/1ps
`default_nettype none
`include "vfs_consts.svh"

module vfs_rail_mon
  import vfs_pkg::*;
#(
  parameter vfs_cnt_t IMB_CYCLES = vfs_cnt_t'(`VFS_IMB_CYCLES),
  parameter vfs_cnt_t OC_CYCLES = vfs_cnt_t'(`VFS_OC_MIN_CYCLES)
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic imbalance_raw,
  input wire logic undervolt_raw,
  input wire logic overvolt_raw,
  input wire logic below_target_raw,
  input wire logic overcurrent_raw,
  input wire logic severe_oc_raw,
  vfs_rail_if.mon bus
);

  ////////////////////////////////////////////////////////////////////////////
  // step a persistence timer; restarts whenever the flag drops
  function automatic vfs_cnt_t timer_step(input logic active, input vfs_cnt_t cnt, input vfs_cnt_t term);
    timer_step = active ? ((cnt == term) ? cnt : cnt + vfs_cnt_t'(1)) : '0;
  endfunction : timer_step

  logic [5:0] meta_ff;
  logic [5:0] sync_ff;
  logic imb_s, uv_s, ov_s, below_s, oc_s, woc_s;
  vfs_cnt_t imb_cnt_ff;
  vfs_cnt_t oc_cnt_ff;
  logic imb_fault_ff, uv_fault_ff, oc_fault_ff, woc_fault_ff;
  vfs_ov_e ov_state_ff;
  logic ov_flag_ff;

  ////////////////////////////////////////////////////////////////////////////
  // two-flop synchroniser for all comparator flags
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      meta_ff <= 6'h00;
      sync_ff <= 6'h00;
    end else begin
      meta_ff <= {severe_oc_raw, overcurrent_raw, below_target_raw, overvolt_raw, undervolt_raw, imbalance_raw};
      sync_ff <= meta_ff;
    end
  end

  assign {woc_s, oc_s, below_s, ov_s, uv_s, imb_s} = sync_ff;

  // continuous-duration timers
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      imb_cnt_ff <= '0;
      oc_cnt_ff <= '0;
    end else begin
      imb_cnt_ff <= timer_step(imb_s & ~bus.clear, imb_cnt_ff, IMB_CYCLES);
      oc_cnt_ff <= timer_step(oc_s & ~bus.clear, oc_cnt_ff, OC_CYCLES);
    end
  end

  // latched faults; a new event beats the clear
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      imb_fault_ff <= 1'b0;
      uv_fault_ff <= 1'b0;
      oc_fault_ff <= 1'b0;
      woc_fault_ff <= 1'b0;
    end else begin
      imb_fault_ff <= (imb_s & (imb_cnt_ff == IMB_CYCLES - vfs_cnt_t'(1))) | (imb_fault_ff & ~bus.clear);
      uv_fault_ff <= (uv_s & bus.run) | (uv_fault_ff & ~bus.clear);
      oc_fault_ff <= (oc_s & (oc_cnt_ff == OC_CYCLES - vfs_cnt_t'(1))) | (oc_fault_ff & ~bus.clear);
      woc_fault_ff <= woc_s | (woc_fault_ff & ~bus.clear);
    end
  end

  // overvoltage discharge: low side on until below target, then tri-state
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ov_state_ff <= VFS_OV_WATCH;
      ov_flag_ff <= 1'b0;
    end else if (bus.clear & ~ov_s) begin
      ov_state_ff <= VFS_OV_WATCH;
      ov_flag_ff <= 1'b0;
    end else begin
      unique case (ov_state_ff)
        VFS_OV_WATCH: begin
          if (ov_s) begin
            ov_state_ff <= VFS_OV_DISCH;
            ov_flag_ff <= 1'b1;
          end
        end
        VFS_OV_DISCH: begin
          if (below_s) begin
            ov_state_ff <= VFS_OV_OFF;
          end
        end
        VFS_OV_OFF: begin
          if (ov_s) begin
            ov_state_ff <= VFS_OV_DISCH;
          end
        end
      endcase
    end
  end

  assign bus.fault_imb = imb_fault_ff;
  assign bus.fault_uv = uv_fault_ff;
  assign bus.fault_oc = oc_fault_ff;
  assign bus.fault_woc = woc_fault_ff;
  assign bus.ov_flag = ov_flag_ff;
  assign bus.ls_on = (ov_state_ff == VFS_OV_DISCH);
  assign bus.oc_alert = oc_s & ~bus.clear;

endmodule : vfs_rail_mon

`default_nettype wire

// ### hdl/vfs_fault_supervisor.sv
// top of the two-rail fault supervisor: sequencing, thermal monitor, outputs
// assumes comparator flags and enable/supply pins are asynchronous to clk
//
// What this block does
// - imbalance flag high for 1ms continuously latches an imbalance fault.
// - undervoltage flag in run latches a fault, drops power-good, tri-states switches.
// - overvoltage flag latches a fault and drops power-good.
// - overvoltage turns low side on until output is below target, then tri-states.
// - a new overvoltage after tri-state repeats the low-side discharge.
// - temperature at or below warning level asserts the active-low thermal alert.
// - thermal warning runs a fault counter worth at least 100us before shutdown.
// - thermal counter counts up while warned, down otherwise.
// - after tripping, the warning release uses the higher reset level.
// - temperature at shutdown level latches thermal fault, drops power-good, tri-states.
// - a thermal fault on either rail shuts both rails down.
// - alert releases only when both temperatures exceed the reset level.
// - faults stay latched even after the condition goes away.
// - only enable low or supply loss clears the latched faults.
// - enable and supply both high ends the clear and starts soft-start.
// - overcurrent persisting 7.5us to 11us latches a fault; early drop clears timer.
// - alert asserts within 2us of an overcurrent flag.
// - severe overcurrent shuts the rail at once with no timer.
// - overcurrent shutdown of one rail shuts the other within 10us.
`timescale 1ns/1ps
`default_nettype none
`include "vfs_consts.svh"

module vfs_fault_supervisor
  import vfs_pkg::*;
#(
  parameter vfs_cnt_t IMB_CYCLES = vfs_cnt_t'(`VFS_IMB_CYCLES),
  parameter vfs_cnt_t OC_CYCLES = vfs_cnt_t'(`VFS_OC_MIN_CYCLES),
  parameter vfs_cnt_t THERM_CYCLES = vfs_cnt_t'(`VFS_THERM_CYCLES),
  parameter vfs_cnt_t SS_CYCLES = vfs_cnt_t'(`VFS_SS_CYCLES)
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic enable_in,
  input wire logic vdd_ok_in,
  input wire logic [1:0] phase_current_sense_in_mismatch,
  input wire logic [1:0] undervolt_in,
  input wire logic [1:0] overvolt_in,
  input wire logic [1:0] below_target_in,
  input wire logic [1:0] overcurrent_in,
  input wire logic [1:0] severe_overcurrent_in,
  input wire logic [1:0] temp_at_trip_in,
  input wire logic [1:0] temp_above_reset_in,
  input wire logic [1:0] temp_at_shutdown_in,
  output logic [1:0] power_good_out,
  output logic [1:0] switching_en,
  output logic [1:0] low_side_on,
  output logic thermal_alert_n,
  output logic soft_start_active,
  output logic [1:0] imbalance_fault,
  output logic [1:0] undervolt_fault,
  output logic [1:0] overvolt_fault,
  output logic [1:0] overcurrent_fault,
  output logic [1:0] severe_overcurrent_fault,
  output logic thermal_fault
);

  ////////////////////////////////////////////////////////////////////////////
  // declarations

  logic [7:0] pin_meta_ff;
  logic [7:0] pin_sync_ff;
  logic enable_s;
  logic vdd_ok_s;
  logic [1:0] trip_s;
  logic [1:0] rst_lvl_s;
  logic [1:0] shut_s;
  logic supply_up;

  vfs_seq_e seq_ff;
  vfs_seq_e nxt_seq;
  vfs_cnt_t ss_cnt_ff;
  vfs_cnt_t nxt_ss_cnt;
  logic clear_faults;

  logic hot_ff;
  logic warn_now;
  vfs_cnt_t therm_cnt_ff;
  logic therm_fault_ff;

  logic [1:0] r_imb, r_uv, r_oc, r_woc, r_ov, r_ls, r_alert;
  logic [1:0] rail_down;
  logic [1:0] nxt_power_good_out;
  logic [1:0] nxt_switch;
  logic nxt_alert_n;

  vfs_rail_if core_if ();
  vfs_rail_if aux_if ();

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  // two flops on enable, supply and the temperature comparators
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pin_meta_ff <= 8'h00;
      pin_sync_ff <= 8'h00;
    end else begin
      pin_meta_ff <= {temp_at_shutdown_in, temp_above_reset_in, temp_at_trip_in, vdd_ok_in, enable_in};
      pin_sync_ff <= pin_meta_ff;
    end
  end

  assign {shut_s, rst_lvl_s, trip_s, vdd_ok_s, enable_s} = pin_sync_ff;
  assign supply_up = enable_s & vdd_ok_s;

  ////////////////////////////////////////////////////////////////////////////
  // power-up sequence

  // off while enable or supply is low; soft-start on their return
  always_comb begin
    nxt_seq = seq_ff;
    nxt_ss_cnt = ss_cnt_ff;
    unique case (seq_ff)
      VFS_SEQ_OFF: begin
        nxt_ss_cnt = '0;
        if (supply_up) begin
          nxt_seq = VFS_SEQ_SOFT;
        end
      end
      VFS_SEQ_SOFT: begin
        if (!supply_up) begin
          nxt_seq = VFS_SEQ_OFF;
        end else if (ss_cnt_ff == SS_CYCLES - vfs_cnt_t'(1)) begin
          nxt_seq = VFS_SEQ_RUN;
        end else begin
          nxt_ss_cnt = ss_cnt_ff + vfs_cnt_t'(1);
        end
      end
      VFS_SEQ_RUN: begin
        if (!supply_up) begin
          nxt_seq = VFS_SEQ_OFF;
        end
      end
    endcase
  end

  // sequence state registers
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      seq_ff <= VFS_SEQ_OFF;
      ss_cnt_ff <= '0;
    end else begin
      seq_ff <= nxt_seq;
      ss_cnt_ff <= nxt_ss_cnt;
    end
  end

  // latches are cleared only while the rail is held off
  assign clear_faults = (seq_ff == VFS_SEQ_OFF);

  ////////////////////////////////////////////////////////////////////////////
  // thermal monitor

  // hysteresis state: trips on either sensor, releases when both are above reset
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      hot_ff <= 1'b0;
    end else if (|trip_s) begin
      hot_ff <= 1'b1;
    end else if (&rst_lvl_s) begin
      hot_ff <= 1'b0;
    end
  end

  // compare level moves to the reset level once tripped
  assign warn_now = hot_ff ? ~(&rst_lvl_s) : (|trip_s);

  // up/down thermal fault counter, saturating at both ends
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      therm_cnt_ff <= '0;
    end else if (warn_now) begin
      if (therm_cnt_ff != THERM_CYCLES) begin
        therm_cnt_ff <= therm_cnt_ff + vfs_cnt_t'(1);
      end
    end else if (therm_cnt_ff != '0) begin
      therm_cnt_ff <= therm_cnt_ff - vfs_cnt_t'(1);
    end
  end

  // thermal fault: shutdown level reached after the least warning time
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      therm_fault_ff <= 1'b0;
    end else begin
      therm_fault_ff <= ((|shut_s) & (therm_cnt_ff == THERM_CYCLES)) | (therm_fault_ff & ~clear_faults);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // rail monitors

  assign core_if.run = (seq_ff == VFS_SEQ_RUN);
  assign core_if.clear = clear_faults;
  assign aux_if.run = (seq_ff == VFS_SEQ_RUN);
  assign aux_if.clear = clear_faults;

  // core rail
  vfs_rail_mon #(
    .IMB_CYCLES(IMB_CYCLES),
    .OC_CYCLES(OC_CYCLES)
  ) u_core_mon (
    .clk(clk),
    .reset(reset),
    .imbalance_raw(phase_current_sense_in_mismatch[`VFS_RAIL_CORE]),
    .undervolt_raw(undervolt_in[`VFS_RAIL_CORE]),
    .overvolt_raw(overvolt_in[`VFS_RAIL_CORE]),
    .below_target_raw(below_target_in[`VFS_RAIL_CORE]),
    .overcurrent_raw(overcurrent_in[`VFS_RAIL_CORE]),
    .severe_oc_raw(severe_overcurrent_in[`VFS_RAIL_CORE]),
    .bus(core_if.mon)
  );

  // auxiliary rail
  vfs_rail_mon #(
    .IMB_CYCLES(IMB_CYCLES),
    .OC_CYCLES(OC_CYCLES)
  ) u_aux_mon (
    .clk(clk),
    .reset(reset),
    .imbalance_raw(phase_current_sense_in_mismatch[`VFS_RAIL_AUX]),
    .undervolt_raw(undervolt_in[`VFS_RAIL_AUX]),
    .overvolt_raw(overvolt_in[`VFS_RAIL_AUX]),
    .below_target_raw(below_target_in[`VFS_RAIL_AUX]),
    .overcurrent_raw(overcurrent_in[`VFS_RAIL_AUX]),
    .severe_oc_raw(severe_overcurrent_in[`VFS_RAIL_AUX]),
    .bus(aux_if.mon)
  );

  // gather rail results into vectors
  assign r_imb = {aux_if.fault_imb, core_if.fault_imb};
  assign r_uv = {aux_if.fault_uv, core_if.fault_uv};
  assign r_oc = {aux_if.fault_oc, core_if.fault_oc};
  assign r_woc = {aux_if.fault_woc, core_if.fault_woc};
  assign r_ov = {aux_if.ov_flag, core_if.ov_flag};
  assign r_ls = {aux_if.ls_on, core_if.ls_on};
  assign r_alert = {aux_if.oc_alert, core_if.oc_alert};

  ////////////////////////////////////////////////////////////////////////////
  // shutdown decision

  // own latched faults, any thermal fault, or an overcurrent on the other rail
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      rail_down[i] = r_imb[i] | r_uv[i] | r_oc[i] | r_woc[i]
                   | therm_fault_ff
                   | r_oc[1-i] | r_woc[1-i];
    end
  end

  // power-good only in run with no fault; overvoltage also drops it
  assign nxt_power_good_out = {2{seq_ff == VFS_SEQ_RUN}} & ~rail_down & ~r_ov;
  // switching stops (tri-state) on any shutdown or overvoltage
  assign nxt_switch = {2{seq_ff != VFS_SEQ_OFF}} & ~rail_down & ~r_ov;
  // alert from thermal warning or a pending overcurrent
  assign nxt_alert_n = ~(hot_ff | (|r_alert));

  ////////////////////////////////////////////////////////////////////////////
  // output registers

  // gate control and power-good
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      power_good_out <= 2'h0;
      switching_en <= 2'h0;
      low_side_on <= 2'h0;
    end else begin
      power_good_out <= nxt_power_good_out;
      switching_en <= nxt_switch;
      low_side_on <= r_ls;
    end
  end

  // alert and soft-start status
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      thermal_alert_n <= 1'b1;
      soft_start_active <= 1'b0;
    end else begin
      thermal_alert_n <= nxt_alert_n;
      soft_start_active <= (seq_ff == VFS_SEQ_SOFT);
    end
  end

  // fault status copies
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      imbalance_fault <= 2'h0;
      undervolt_fault <= 2'h0;
      overvolt_fault <= 2'h0;
      overcurrent_fault <= 2'h0;
      severe_overcurrent_fault <= 2'h0;
      thermal_fault <= 1'b0;
    end else begin
      imbalance_fault <= r_imb;
      undervolt_fault <= r_uv;
      overvolt_fault <= r_ov;
      overcurrent_fault <= r_oc;
      severe_overcurrent_fault <= r_woc;
      thermal_fault <= therm_fault_ff;
    end
  end

endmodule : vfs_fault_supervisor

`default_nettype wire

// ### tb/vfs_fault_supervisor_sva.sv
// checker for the two-rail fault supervisor, top ports only
// assumes counts come from the bind below
`timescale 1ns/1ps
`default_nettype none

module vfs_fault_supervisor_sva
  import vfs_pkg::*;
#(
  parameter vfs_cnt_t IMB_CYCLES = 16'h0014,
  parameter vfs_cnt_t OC_CYCLES = 16'h000A
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic enable_in,
  input wire logic vdd_ok_in,
  input wire logic [1:0] phase_current_sense_in_mismatch,
  input wire logic [1:0] overcurrent_in,
  input wire logic [1:0] severe_overcurrent_in,
  input wire logic [1:0] temp_at_trip_in,
  input wire logic [1:0] power_good_out,
  input wire logic [1:0] switching_en,
  input wire logic [1:0] low_side_on,
  input wire logic thermal_alert_n,
  input wire logic soft_start_active,
  input wire logic [1:0] imbalance_fault,
  input wire logic [1:0] undervolt_fault,
  input wire logic [1:0] overvolt_fault,
  input wire logic [1:0] overcurrent_fault,
  input wire logic [1:0] severe_overcurrent_fault,
  input wire logic thermal_fault
);
  ////////////////////////////////
  // one clock, reset aborts attempts
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  // alert and timer relations
  property p_oc_alert; (overcurrent_in != 2'h0) [*5] |-> !thermal_alert_n; endproperty
  a_oc_alert: assert property (p_oc_alert) else $error("no alert on overcurrent");
  property p_temp_alert; (temp_at_trip_in != 2'h0) [*5] |-> !thermal_alert_n; endproperty
  a_temp_alert: assert property (p_temp_alert) else $error("no alert on warning");
  property p_oc_time; $rose(overcurrent_fault[0]) |-> $past(overcurrent_in[0], OC_CYCLES); endproperty
  a_oc_time: assert property (p_oc_time) else $error("overcurrent fault too early");
  property p_imb; $rose(imbalance_fault[0]) |-> $past(phase_current_sense_in_mismatch[0], IMB_CYCLES); endproperty
  a_imb: assert property (p_imb) else $error("imbalance fault too early");
  property p_woc; severe_overcurrent_in[1] [*5] |-> severe_overcurrent_fault[1] && power_good_out == 2'h0; endproperty
  a_woc: assert property (p_woc) else $error("severe overcurrent not acted on");

  // shutdown actions
  property p_uv; $rose(undervolt_fault[0]) |-> !power_good_out[0] && !switching_en[0]; endproperty
  a_uv: assert property (p_uv) else $error("undervolt left rail running");
  property p_ov; $rose(overvolt_fault[1]) |-> low_side_on[1] && !power_good_out[1]; endproperty
  a_ov: assert property (p_ov) else $error("overvolt without discharge");
  property p_therm; $rose(thermal_fault) |-> ##[0:2] (power_good_out == 2'h0 && switching_en == 2'h0); endproperty
  a_therm: assert property (p_therm) else $error("thermal fault left a rail on");
  property p_latch; (enable_in && vdd_ok_in) [*6] ##0 thermal_fault |=> thermal_fault; endproperty
  a_latch: assert property (p_latch) else $error("thermal fault dropped while enabled");
  property p_soft; $rose(soft_start_active) |-> (power_good_out == 2'h0) [*4]; endproperty
  a_soft: assert property (p_soft) else $error("power good during soft start");

  // main scenarios reached
  c_oc: cover property ($rose(overcurrent_fault[0]));
  c_therm: cover property ($rose(thermal_fault));
  c_disch: cover property ($fell(low_side_on[1]));
endmodule : vfs_fault_supervisor_sva

bind vfs_fault_supervisor vfs_fault_supervisor_sva #(.IMB_CYCLES(IMB_CYCLES), .OC_CYCLES(OC_CYCLES)) u_sva (
  .clk, .reset, .enable_in, .vdd_ok_in, .phase_current_sense_in_mismatch, .overcurrent_in, .severe_overcurrent_in,
  .temp_at_trip_in, .power_good_out, .switching_en, .low_side_on, .thermal_alert_n, .soft_start_active,
  .imbalance_fault, .undervolt_fault, .overvolt_fault, .overcurrent_fault, .severe_overcurrent_fault, .thermal_fault);

`default_nettype wire

// ### tb/vfs_host_model.sv
// host processor model: owns the enable pin, watches alert and power good
// assumes the bench says when the host wants the rails running
`timescale 1ns/1ps
`default_nettype none

module vfs_host_model (
  input wire logic clk,
  input wire logic want_on,
  input wire logic thermal_alert_n,
  input wire logic [1:0] power_good_out,
  output logic enable_in,
  output var int throttle_cnt
);
  // enable low is the host's only way to clear latched faults
  assign enable_in = want_on;

  // cycles spent throttling while a rail is still good
  always_ff @(posedge clk) begin
    if (!thermal_alert_n && power_good_out != 2'h0) begin
      throttle_cnt <= throttle_cnt + 1;
    end
  end
endmodule : vfs_host_model

`default_nettype wire

// ### tb/tb.sv
// self-checking bench for the two-rail fault supervisor
// assumes shortened counts: imbalance 20, overcurrent 10, thermal 16, soft-start 8
`timescale 1ns/1ps
`default_nettype none

module tb;
  import vfs_pkg::*;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic want_on = 1'b0;
  logic vdd_ok_in = 1'b1;
  logic [1:0] phase_current_sense_in_mismatch = 2'h0;
  logic [1:0] undervolt_in = 2'h0;
  logic [1:0] overvolt_in = 2'h0;
  logic [1:0] below_target_in = 2'h0;
  logic [1:0] overcurrent_in = 2'h0;
  logic [1:0] severe_overcurrent_in = 2'h0;
  logic [1:0] temp_at_trip_in = 2'h0;
  logic [1:0] temp_above_reset_in = 2'h3;
  logic [1:0] temp_at_shutdown_in = 2'h0;
  logic enable_in, thermal_alert_n, soft_start_active, thermal_fault;
  logic [1:0] power_good_out, switching_en, low_side_on, imbalance_fault, undervolt_fault;
  logic [1:0] overvolt_fault, overcurrent_fault, severe_overcurrent_fault;
  int throttle_cnt;
  int fails = 0;
  int n_tests = 0;

  ////////////////////////////////
  vfs_fault_supervisor #(.IMB_CYCLES(16'h0014), .OC_CYCLES(16'h000A), .THERM_CYCLES(16'h0010),
    .SS_CYCLES(16'h0008)) u_dut (.clk, .reset, .enable_in, .vdd_ok_in, .phase_current_sense_in_mismatch,
    .undervolt_in, .overvolt_in, .below_target_in, .overcurrent_in, .severe_overcurrent_in,
    .temp_at_trip_in, .temp_above_reset_in, .temp_at_shutdown_in, .power_good_out, .switching_en,
    .low_side_on, .thermal_alert_n, .soft_start_active, .imbalance_fault, .undervolt_fault,
    .overvolt_fault, .overcurrent_fault, .severe_overcurrent_fault, .thermal_fault);
  vfs_host_model u_host (.clk, .want_on, .thermal_alert_n, .power_good_out, .enable_in, .throttle_cnt);

  // 40 MHz clock
  always #12.5 clk = ~clk;

  ////////////////////////////////
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask : cyc

  task automatic chk(input string what, input logic [1:0] exp, input logic [1:0] got);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic wait_up();
    for (int i = 0; i < 60 && power_good_out !== 2'h3; i++) begin
      cyc(1);
    end
    chk("power_good_out", 2'h3, power_good_out);
  endtask : wait_up

  // clear through enable or supply, then soft-start again
  task automatic restart(input bit by_vdd);
    vdd_ok_in = !by_vdd;
    want_on = by_vdd;
    cyc(4);
    vdd_ok_in = 1'b1;
    want_on = 1'b1;
    wait_up();
  endtask : restart

  ////////////////////////////////
  task automatic t_start();
    chk("thermal_alert_n", 2'h1, {1'b0, thermal_alert_n});
    chk("power_good_out", 2'h0, power_good_out);
    want_on = 1'b1;
    cyc(5);
    chk("soft_start_active", 2'h1, {1'b0, soft_start_active});
    wait_up();
    chk("switching_en", 2'h3, switching_en);
    $display("test start done");
  endtask : t_start

  task automatic t_oc();
    overcurrent_in = 2'h1;
    cyc(4);
    chk("thermal_alert_n", 2'h0, {1'b0, thermal_alert_n});
    cyc(3);
    overcurrent_in = 2'h0;
    cyc(4);
    chk("thermal_alert_n", 2'h1, {1'b0, thermal_alert_n});
    chk("overcurrent_fault", 2'h0, overcurrent_fault);
    overcurrent_in = 2'h1;
    cyc(8);
    chk("overcurrent_fault", 2'h0, overcurrent_fault);
    cyc(10);
    chk("overcurrent_fault0", 2'h1, {1'b0, overcurrent_fault[0]});
    chk("power_good_out", 2'h0, power_good_out);
    chk("switching_en", 2'h0, switching_en);
    overcurrent_in = 2'h0;
    cyc(5);
    chk("overcurrent_fault0", 2'h1, {1'b0, overcurrent_fault[0]});
    restart(1'b0);
    chk("overcurrent_fault", 2'h0, overcurrent_fault);
    $display("test overcurrent done");
  endtask : t_oc

  task automatic t_woc();
    severe_overcurrent_in = 2'h2;
    cyc(5);
    chk("severe_overcurrent_fault1", 2'h1, {1'b0, severe_overcurrent_fault[1]});
    chk("power_good_out", 2'h0, power_good_out);
    severe_overcurrent_in = 2'h0;
    restart(1'b1);
    chk("severe_overcurrent_fault", 2'h0, severe_overcurrent_fault);
    $display("test severe overcurrent done");
  endtask : t_woc

  task automatic t_uv();
    undervolt_in = 2'h1;
    cyc(5);
    chk("undervolt_fault", 2'h1, undervolt_fault);
    chk("power_good_out", 2'h2, power_good_out);
    chk("switching_en", 2'h2, switching_en);
    undervolt_in = 2'h0;
    cyc(4);
    chk("undervolt_fault", 2'h1, undervolt_fault);
    chk("power_good_out", 2'h2, power_good_out);
    restart(1'b0);
    $display("test undervolt done");
  endtask : t_uv

  task automatic t_ov();
    for (int k = 0; k < 2; k++) begin
      overvolt_in = 2'h2;
      cyc(5);
      chk("overvolt_fault", 2'h2, overvolt_fault);
      chk("power_good_out", 2'h1, power_good_out);
      chk("low_side_on", 2'h2, low_side_on);
      overvolt_in = 2'h0;
      below_target_in = 2'h2;
      cyc(5);
      chk("low_side_on", 2'h0, low_side_on);
      below_target_in = 2'h0;
    end
    restart(1'b0);
    $display("test overvolt done");
  endtask : t_ov

  task automatic t_imb();
    phase_current_sense_in_mismatch = 2'h1;
    cyc(15);
    chk("imbalance_fault", 2'h0, imbalance_fault);
    cyc(15);
    chk("imbalance_fault", 2'h1, imbalance_fault);
    chk("power_good_out", 2'h2, power_good_out);
    phase_current_sense_in_mismatch = 2'h0;
    restart(1'b0);
    chk("imbalance_fault", 2'h0, imbalance_fault);
    $display("test imbalance done");
  endtask : t_imb

  // trip, hysteresis band, then release
  task automatic t_hot();
    int n0 = throttle_cnt;
    temp_at_trip_in = 2'h1;
    temp_above_reset_in = 2'h2;
    cyc(5);
    chk("thermal_alert_n", 2'h0, {1'b0, thermal_alert_n});
    temp_at_trip_in = 2'h0;
    cyc(5);
    chk("thermal_alert_n", 2'h0, {1'b0, thermal_alert_n});
    temp_above_reset_in = 2'h1;
    cyc(5);
    chk("thermal_alert_n", 2'h0, {1'b0, thermal_alert_n});
    temp_above_reset_in = 2'h3;
    cyc(5);
    chk("thermal_alert_n", 2'h1, {1'b0, thermal_alert_n});
    chk("throttle_cnt", 2'h1, {1'b0, throttle_cnt - n0 == 15});
    chk("thermal_fault", 2'h0, {1'b0, thermal_fault});
    $display("test thermal alert done");
  endtask : t_hot

  // counter must drain while cool, then need its full count
  task automatic t_therm();
    cyc(20);
    temp_at_trip_in = 2'h1;
    temp_above_reset_in = 2'h2;
    cyc(12);
    temp_at_trip_in = 2'h0;
    temp_above_reset_in = 2'h3;
    cyc(14);
    temp_at_trip_in = 2'h1;
    temp_above_reset_in = 2'h2;
    temp_at_shutdown_in = 2'h1;
    cyc(12);
    chk("thermal_fault", 2'h0, {1'b0, thermal_fault});
    cyc(14);
    chk("thermal_fault", 2'h1, {1'b0, thermal_fault});
    chk("power_good_out", 2'h0, power_good_out);
    chk("switching_en", 2'h0, switching_en);
    temp_at_trip_in = 2'h0;
    temp_above_reset_in = 2'h3;
    temp_at_shutdown_in = 2'h0;
    cyc(5);
    chk("thermal_fault", 2'h1, {1'b0, thermal_fault});
    restart(1'b0);
    chk("thermal_fault", 2'h0, {1'b0, thermal_fault});
    $display("test thermal shutdown done");
  endtask : t_therm

  ////////////////////////////////
  task automatic results();
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : results

  // main sequence
  initial begin
    repeat (10) @(posedge clk);
    #2;
    reset = 1'b0;
    t_start();
    t_oc();
    t_woc();
    t_uv();
    t_ov();
    t_imb();
    t_hot();
    t_therm();
    results();
  end

  // watchdog: tests need well under 1000 cycles
  initial begin
    #(3000 * 25);
    fails++;
    results();
  end
endmodule : tb

`default_nettype wire
